// [rtl/recorder_mode_control.sv]
// Recorder mode control: panel handling, state machine, APB registers
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module recorder_mode_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic powerSwitch,
  input wire logic recordSwitch,
  input wire logic overrideSwitch,
  input wire logic resetButton,
  input wire logic consolePresent,
  input wire logic faultDetect,
  input wire logic tapeEnd,
  input wire logic tapeWrite,
  input wire logic selfTestDone,
  input wire logic selfTestFail,
  input wire logic cfgReady,
  input wire logic cfgDone,
  input wire logic blockWordDone,
  input wire logic [31:0] playTime,
  input wire logic triggerActive,
  output logic hostIrq,
  output logic collectEnable,
  output logic overrideAll,
  output logic transmitMode,
  output logic [recorder_pkg::BUS_COUNT-1:0] busEnable,
  output logic [2:0] triggerSelect,
  output logic smartRecord,
  output logic holdDiscard,
  output logic reconfigure,
  output logic selfTestStart,
  output logic markerWrite,
  output logic tapeSeek,
  output logic blockDone,
  output logic [31:0] cfgData,
  output logic cfgStrobe,
  output logic faultLamp,
  output logic tapeOutLamp,
  output logic writtenLamp
);
  import recorder_pkg::*;

  // Two-stage synchronisers and edge detect on panel inputs
  logic [3:0] syncA_q, syncB_q, prev_q;
  logic [3:0] rawIn, chg, rise;
  assign rawIn = {resetButton, overrideSwitch, recordSwitch, powerSwitch};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          syncA_q[gi] <= 1'b0;
          syncB_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          syncA_q[gi] <= rawIn[gi];
          syncB_q[gi] <= syncA_q[gi];
          prev_q[gi] <= syncB_q[gi];
        end
      end
      assign chg[gi] = syncB_q[gi] ^ prev_q[gi];
      assign rise[gi] = syncB_q[gi] & ~prev_q[gi];
    end
  endgenerate

  logic powerOn;
  assign powerOn = syncB_q[EV_POWER];

  state_type state_q;
  reset_step_type step_q;
  logic override_q, fault_q, tapeOut_q, written_q, console_q;
  logic [31:0] ctrl_q, playStart_q, playStop_q, cfgData_q, rdata_q;
  logic [31:0] blockCnt_q;
  logic [31:0] bufCnt_q;
  logic [EV_COUNT-1:0] events_q;
  logic cfgStrobe_q, panelIgnore, startPlayOk;

  // APB decode
  logic apbWrite, apbRead, mapped;
  assign apbWrite = psel & penable & pwrite;
  assign apbRead = psel & penable & ~pwrite;
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == CTRL_OFFSET) || (a == CONFIG_OFFSET) || (a == STATUS_OFFSET)
      || (a == FAULT_OFFSET) || (a == PLAYSTART_OFFSET) || (a == PLAYSTOP_OFFSET)
      || (a == EVENT_OFFSET);
  endfunction
  assign mapped = isMapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (~mapped | (pwrite & (paddr == STATUS_OFFSET)));

  assign panelIgnore = (state_q == ST_PLAYBACK) || (state_q == ST_SEEK);
  assign startPlayOk = (playStart_q <= PLAYBACK_MAX_MS) && (playStart_q <= playStop_q);

  // Main state machine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else if (!powerOn) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: state_q <= ST_INIT;
        ST_INIT: begin
          if (cfgDone) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (chg[EV_RECORD]) begin
            state_q <= ST_RECORD;
          end else if (console_q && apbWrite && paddr == CTRL_OFFSET
                       && pwdata[1:0] == MODE_PLAYBACK && pwdata[CTRL_COLLECT_BIT]
                       && startPlayOk) begin
            state_q <= ST_SEEK;
          end
        end
        ST_RECORD: begin
          if (tapeEnd) begin
            state_q <= ST_IDLE;
          end else if (chg[EV_RECORD]) begin
            state_q <= ST_IDLE;
          end else if (rise[EV_RESET]) begin
            state_q <= ST_SOFTRESET;
          end
        end
        ST_SOFTRESET: begin
          if (step_q == SR_DONE) begin
            state_q <= ST_RECORD;
          end
        end
        ST_SEEK: begin
          if (playTime >= playStart_q) begin
            state_q <= ST_PLAYBACK;
          end
        end
        ST_PLAYBACK: begin
          if (tapeEnd || playTime >= playStop_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // Soft reset sequence
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= SR_DUMP;
    end else if (state_q != ST_SOFTRESET) begin
      step_q <= SR_DUMP;
    end else begin
      case (step_q)
        SR_DUMP: step_q <= SR_RECONF;
        SR_RECONF: step_q <= SR_SELFTEST;
        SR_SELFTEST: begin
          if (selfTestDone) begin
            step_q <= SR_MARKER;
          end
        end
        SR_MARKER: step_q <= SR_DONE;
        SR_DONE: step_q <= SR_DONE;
        default: step_q <= SR_DUMP;
      endcase
    end
  end

  // Override flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      override_q <= 1'b0;
    end else if (state_q != ST_RECORD && state_q != ST_SOFTRESET) begin
      override_q <= 1'b0;
    end else if (state_q == ST_RECORD && chg[EV_OVERRIDE]) begin
      override_q <= syncB_q[EV_OVERRIDE];
    end
  end

  // Lamps and console strap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
      tapeOut_q <= 1'b0;
      written_q <= 1'b0;
      console_q <= 1'b0;
    end else begin
      if (faultDetect || (step_q == SR_SELFTEST && selfTestDone && selfTestFail)) begin
        fault_q <= 1'b1;
      end else if (state_q == ST_OFF || step_q == SR_DUMP && state_q == ST_SOFTRESET) begin
        fault_q <= 1'b0;
      end
      if (tapeEnd && state_q != ST_OFF) begin
        tapeOut_q <= 1'b1;
      end else if (state_q == ST_OFF) begin
        tapeOut_q <= 1'b0;
      end
      if (tapeWrite && state_q != ST_OFF) begin
        written_q <= 1'b1;
      end else if (state_q == ST_OFF && powerOn) begin
        written_q <= 1'b0;
      end
      if (state_q == ST_OFF) begin
        console_q <= consolePresent;
      end
    end
  end

  // Host registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      playStart_q <= 32'h0000_0000;
      playStop_q <= PLAYSTOP_RESET;
      cfgData_q <= 32'h0000_0000;
      cfgStrobe_q <= 1'b0;
    end else begin
      cfgStrobe_q <= 1'b0;
      if (state_q == ST_OFF) begin
        ctrl_q <= CTRL_RESET;
        ctrl_q[CTRL_TRIG_LSB +: 3] <= TRIG_RESET;
      end else if (apbWrite && paddr == CTRL_OFFSET) begin
        ctrl_q <= pwdata;
      end
      if (apbWrite && paddr == CONFIG_OFFSET && (state_q == ST_INIT || state_q == ST_IDLE)) begin
        cfgData_q <= pwdata;
        cfgStrobe_q <= 1'b1;
      end
      if (apbWrite && paddr == PLAYSTART_OFFSET && pwdata <= PLAYBACK_MAX_MS) begin
        playStart_q <= pwdata;
      end
      if (apbWrite && paddr == PLAYSTOP_OFFSET && pwdata <= PLAYBACK_MAX_MS) begin
        playStop_q <= pwdata;
      end
    end
  end

  // Panel events, cleared by write-one; set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      events_q <= '0;
    end else begin
      for (int i = 0; i < EV_COUNT; i++) begin
        if ((i == EV_POWER && chg[i]) || (i == EV_RECORD && chg[i] && !panelIgnore
            && (state_q == ST_IDLE || state_q == ST_RECORD))
            || (i == EV_OVERRIDE && chg[i] && state_q == ST_RECORD)
            || (i == EV_RESET && rise[i] && state_q == ST_RECORD)) begin
          events_q[i] <= 1'b1;
        end else if (apbWrite && paddr == EVENT_OFFSET && pwdata[i]) begin
          events_q[i] <= 1'b0;
        end
      end
    end
  end

  // Playback block counter and smart buffer timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blockCnt_q <= '0;
      bufCnt_q <= '0;
    end else begin
      if (state_q != ST_PLAYBACK) begin
        blockCnt_q <= '0;
      end else if (blockWordDone) begin
        blockCnt_q <= (blockCnt_q == PLAYBACK_BLOCK_WORDS - 1) ? '0 : blockCnt_q + 32'h1;
      end
      if (state_q != ST_RECORD || triggerActive) begin
        bufCnt_q <= '0;
      end else if (bufCnt_q != BUFFER_TIME_CYCLES) begin
        bufCnt_q <= bufCnt_q + 32'h1;
      end
    end
  end

  // Read data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        CTRL_OFFSET: rdata_q <= ctrl_q;
        CONFIG_OFFSET: rdata_q <= cfgData_q;
        STATUS_OFFSET: rdata_q <= {20'h0, bufCnt_q == BUFFER_TIME_CYCLES, written_q, tapeOut_q,
          fault_q, console_q, override_q, cfgDone, cfgReady, 1'b0, state_q};
        FAULT_OFFSET: rdata_q <= {30'h0, selfTestFail, fault_q};
        PLAYSTART_OFFSET: rdata_q <= playStart_q;
        PLAYSTOP_OFFSET: rdata_q <= playStop_q;
        EVENT_OFFSET: rdata_q <= {28'h0, events_q};
        default: rdata_q <= '0;
      endcase
    end
  end
  assign prdata = apbRead ? rdata_q : '0;

  assign hostIrq = |events_q;
  assign collectEnable = (state_q == ST_RECORD) && ctrl_q[CTRL_COLLECT_BIT];
  assign overrideAll = override_q;
  assign transmitMode = (state_q == ST_PLAYBACK);
  assign busEnable = ctrl_q[CTRL_BUS_LSB +: BUS_COUNT];
  assign triggerSelect = ctrl_q[CTRL_TRIG_LSB +: 3];
  assign smartRecord = ctrl_q[CTRL_SMART_BIT] & ~override_q & (bufCnt_q != BUFFER_TIME_CYCLES
    | triggerActive);
  assign holdDiscard = (state_q == ST_OFF)
    || (state_q == ST_SOFTRESET && step_q == SR_DUMP);
  assign reconfigure = (state_q == ST_SOFTRESET && step_q == SR_RECONF);
  assign selfTestStart = (state_q == ST_SOFTRESET && step_q == SR_RECONF);
  assign markerWrite = (state_q == ST_SOFTRESET && step_q == SR_MARKER);
  assign tapeSeek = (state_q == ST_SEEK);
  assign blockDone = (state_q == ST_PLAYBACK) && blockWordDone
    && (blockCnt_q == PLAYBACK_BLOCK_WORDS - 1);
  assign cfgData = cfgData_q;
  assign cfgStrobe = cfgStrobe_q;
  assign faultLamp = fault_q;
  assign tapeOutLamp = tapeOut_q;
  assign writtenLamp = written_q;

  // Checks
  sequence s_reset_walk;
    step_q == SR_DUMP ##1 step_q == SR_RECONF ##1 step_q == SR_SELFTEST;
  endsequence

  chk_power_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !powerOn |=> state_q == ST_OFF) else $error("state not off after power drop");
  chk_idle_after_init: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_INIT && cfgDone && powerOn |=> state_q == ST_IDLE)
    else $error("init did not reach idle");
  chk_record_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_IDLE && chg[EV_RECORD] && powerOn
    |=> state_q == ST_RECORD && events_q[EV_RECORD])
    else $error("record press did not start recording");
  chk_record_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_RECORD && chg[EV_RECORD] && powerOn |=> state_q == ST_IDLE)
    else $error("record press did not stop");
  chk_override_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_RECORD && powerOn && chg[EV_OVERRIDE] && syncB_q[EV_OVERRIDE] && !chg[EV_RECORD]
    && !tapeEnd |=> overrideAll) else $error("override not set");
  chk_soft_reset_order: assert property (@(posedge sys_clk)
    disable iff (!rst_n || !powerOn) $rose(state_q == ST_SOFTRESET) |-> s_reset_walk)
    else $error("soft reset order broken");
  chk_tape_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_RECORD && tapeEnd && powerOn |=> state_q == ST_IDLE && tapeOutLamp)
    else $error("tape end not handled");
  chk_written_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writtenLamp && state_q != ST_OFF |=> writtenLamp) else $error("written lamp lost");
  chk_panel_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_PLAYBACK && !tapeEnd && playTime < playStop_q && powerOn
    |=> state_q == ST_PLAYBACK)
    else $error("playback left early");
endmodule // recorder_mode_control
`default_nettype wire

// [rtl/recorder_pkg.sv]
// Package: register map, fields, reset values, states and timing for the recorder control
package recorder_pkg;

  localparam int CLK_HZ = 40000000;
  localparam int BUFFER_TIME_S = 10;
  localparam int BUFFER_TIME_CYCLES = BUFFER_TIME_S * CLK_HZ;
  localparam int PLAYBACK_MAX_MS = 15960000;
  localparam int PLAYBACK_BLOCK_WORDS = 5000;
  localparam int TIME_MS_CYCLES = CLK_HZ / 1000;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] FAULT_OFFSET = 8'h0C;
  localparam logic [7:0] PLAYSTART_OFFSET = 8'h10;
  localparam logic [7:0] PLAYSTOP_OFFSET = 8'h14;
  localparam logic [7:0] EVENT_OFFSET = 8'h18;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COLLECT_BIT = 2;
  localparam int CTRL_BUS_LSB = 8;
  localparam int BUS_COUNT = 7;
  localparam int CTRL_TRIG_LSB = 16;
  localparam int CTRL_SMART_BIT = 20;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

  localparam logic [1:0] MODE_RECORD = 2'h0;
  localparam logic [1:0] MODE_PLAYBACK = 2'h1;
  localparam logic [1:0] MODE_SELFTEST = 2'h2;

  // Trigger modes: acquisition, track, burst ranging as a 3-bit selection
  localparam logic [2:0] TRIG_RESET = 3'h7;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CFGREADY_BIT = 4;
  localparam int STAT_CFGDONE_BIT = 5;
  localparam int STAT_OVERRIDE_BIT = 6;
  localparam int STAT_CONSOLE_BIT = 7;
  localparam int STAT_FAULT_BIT = 8;
  localparam int STAT_TAPEOUT_BIT = 9;
  localparam int STAT_WRITTEN_BIT = 10;
  localparam int STAT_BUFFULL_BIT = 11;

  // Event register bits
  localparam int EV_POWER = 0;
  localparam int EV_RECORD = 1;
  localparam int EV_OVERRIDE = 2;
  localparam int EV_RESET = 3;
  localparam int EV_COUNT = 4;

  localparam logic [31:0] PLAYSTOP_RESET = 32'h00F3_87C0;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_INIT = 3'b001,
    ST_IDLE = 3'b011,
    ST_RECORD = 3'b010,
    ST_SOFTRESET = 3'b110,
    ST_PLAYBACK = 3'b111,
    ST_SEEK = 3'b101
  } state_type;

  typedef enum logic [2:0] {
    SR_DUMP = 3'b000,
    SR_RECONF = 3'b001,
    SR_SELFTEST = 3'b011,
    SR_MARKER = 3'b010,
    SR_DONE = 3'b110
  } reset_step_type;

endpackage

// [testbench/recorder_env_model.sv]
// Far-side model: tape unit, self-test engine and configuration handshake
`timescale 1ns/1ps
`default_nettype none
module recorder_env_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic selfTestStart,
  input wire logic markerWrite,
  input wire logic tapeSeek,
  input wire logic transmitMode,
  input wire logic collectEnable,
  output logic selfTestDone,
  output logic selfTestFail,
  output logic cfgReady,
  output logic cfgDone,
  output logic tapeWrite,
  output logic blockWordDone,
  output logic [31:0] playTime,
  output logic [31:0] markerCount
);
  logic [1:0] testDelay_q;
  assign selfTestFail = 1'h0;
  assign cfgReady = 1'h1;
  assign cfgDone = 1'h1;
  // Self test answers three cycles after it is started
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      testDelay_q <= 2'h0;
      selfTestDone <= 1'h0;
    end else begin
      testDelay_q <= {testDelay_q[0], selfTestStart};
      selfTestDone <= testDelay_q[1];
    end
  end
  // Tape writes while collecting, one word each transmit cycle, time advances on motion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tapeWrite <= 1'h0;
      blockWordDone <= 1'h0;
      playTime <= 32'h0;
      markerCount <= 32'h0;
    end else begin
      tapeWrite <= collectEnable;
      blockWordDone <= transmitMode;
      if (tapeSeek || transmitMode) begin
        playTime <= playTime + 32'h1;
      end
      if (markerWrite) begin
        markerCount <= markerCount + 32'h1;
      end
    end
  end
endmodule // recorder_env_model
`default_nettype wire

// [testbench/tb_top.sv]
// Testbench: APB host, panel stimulus and checks for the recorder mode control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import recorder_pkg::*;
  logic sys_clk = 1'h0, rst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, playTime, cfgData, markerCount, rdData;
  logic pready, pslverr, rdErr;
  logic powerSwitch = 1'h0, recordSwitch = 1'h0, overrideSwitch = 1'h0, resetButton = 1'h0;
  logic consolePresent = 1'h0, faultDetect = 1'h0, tapeEnd = 1'h0, triggerActive = 1'h0;
  logic tapeWrite, selfTestDone, selfTestFail, cfgReady, cfgDone, blockWordDone;
  logic hostIrq, collectEnable, overrideAll, transmitMode, smartRecord, holdDiscard;
  logic reconfigure, selfTestStart, markerWrite, tapeSeek, blockDone, cfgStrobe;
  logic faultLamp, tapeOutLamp, writtenLamp;
  logic [BUS_COUNT-1:0] busEnable;
  logic [2:0] triggerSelect;
  int mismatches = 0, nTests = 0, cycles = 0, blockCount = 0, strobeCount = 0, reconfCount = 0;
  int i;

  always #12.5 sys_clk = ~sys_clk;

  recorder_mode_control uut (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .powerSwitch, .recordSwitch, .overrideSwitch, .resetButton, .consolePresent, .faultDetect,
    .tapeEnd, .tapeWrite, .selfTestDone, .selfTestFail, .cfgReady, .cfgDone, .blockWordDone,
    .playTime, .triggerActive, .hostIrq, .collectEnable, .overrideAll, .transmitMode,
    .busEnable, .triggerSelect, .smartRecord, .holdDiscard, .reconfigure, .selfTestStart,
    .markerWrite, .tapeSeek, .blockDone, .cfgData, .cfgStrobe, .faultLamp, .tapeOutLamp,
    .writtenLamp
  );

  recorder_env_model env (
    .sys_clk, .rst_n, .selfTestStart, .markerWrite, .tapeSeek, .transmitMode, .collectEnable,
    .selfTestDone, .selfTestFail, .cfgReady, .cfgDone, .tapeWrite, .blockWordDone, .playTime,
    .markerCount
  );

  always @(posedge sys_clk) begin
    if (blockDone === 1'h1) blockCount <= blockCount + 1;
    if (cfgStrobe === 1'h1) strobeCount <= strobeCount + 1;
    if (reconfigure === 1'h1) reconfCount <= reconfCount + 1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      $display("[FAIL] t=%0t timeout", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  // One APB transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1) @(posedge sys_clk);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'h0, addr, 32'h0);
    chk32(rdData & mask, exp);
  endtask

  // Reads status until the masked field matches, bounded by lim reads
  task automatic poll(input logic [31:0] mask, input logic [31:0] exp, input int lim);
    int n;
    apb(1'h0, STATUS_OFFSET, 32'h0);
    for (n = 1; n < lim && (rdData & mask) !== exp; n++) apb(1'h0, STATUS_OFFSET, 32'h0);
    chk32(rdData & mask, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    rdchk(CTRL_OFFSET, 32'hFFFF_FFFF, CTRL_RESET | (32'(TRIG_RESET) << CTRL_TRIG_LSB));
    rdchk(PLAYSTOP_OFFSET, 32'hFFFF_FFFF, PLAYSTOP_RESET);
    apb(1'h1, STATUS_OFFSET, 32'hFFFF_FFFF);
    chk1(rdErr, 1'h1);
    apb(1'h0, 8'h1C, 32'h0);
    chk1(rdErr, 1'h1);
    poll(32'h7, 32'(ST_OFF), 1);
    $display("test reset values done");
    powerSwitch <= 1'h1;
    poll(32'h7, 32'(ST_IDLE), 100);
    rdchk(EVENT_OFFSET, 32'h1, 32'h1);
    chk1(hostIrq, 1'h1);
    apb(1'h1, EVENT_OFFSET, 32'h0000_000F);
    settle();
    chk1(hostIrq, 1'h0);
    apb(1'h1, CONFIG_OFFSET, 32'hA5A5_0001);
    settle();
    chk32(cfgData, 32'hA5A5_0001);
    chk32(strobeCount, 32'h1);
    $display("test power on done");
    apb(1'h1, CTRL_OFFSET, 32'h0013_7F04);
    recordSwitch <= 1'h1;
    poll(32'h7, 32'(ST_RECORD), 50);
    rdchk(EVENT_OFFSET, 32'h2, 32'h2);
    settle();
    chk1(collectEnable, 1'h1);
    chk32({25'h0, busEnable}, 32'h7F);
    chk32({29'h0, triggerSelect}, 32'h3);
    chk1(writtenLamp, 1'h1);
    chk1(smartRecord, 1'h1);
    apb(1'h1, CONFIG_OFFSET, 32'h1234_5678);
    settle();
    chk32(strobeCount, 32'h1);
    $display("test record done");
    overrideSwitch <= 1'h1;
    poll(32'h40, 32'h40, 50);
    chk1(overrideAll, 1'h1);
    chk1(smartRecord, 1'h0);
    rdchk(EVENT_OFFSET, 32'h4, 32'h4);
    overrideSwitch <= 1'h0;
    poll(32'h40, 32'h0, 50);
    chk1(overrideAll, 1'h0);
    $display("test override done");
    faultDetect <= 1'h1;
    @(posedge sys_clk);
    faultDetect <= 1'h0;
    settle();
    chk1(faultLamp, 1'h1);
    rdchk(FAULT_OFFSET, 32'h3, 32'h1);
    resetButton <= 1'h1;
    repeat (4) @(posedge sys_clk);
    resetButton <= 1'h0;
    for (i = 0; i < 200 && markerCount == 32'h0; i++) @(posedge sys_clk);
    poll(32'h7, 32'(ST_RECORD), 50);
    chk32(markerCount, 32'h1);
    chk1(faultLamp, 1'h0);
    chk32(reconfCount, 32'h1);
    $display("test soft reset done");
    recordSwitch <= 1'h0;
    poll(32'h7, 32'(ST_IDLE), 50);
    settle();
    chk1(collectEnable, 1'h0);
    chk1(writtenLamp, 1'h1);
    recordSwitch <= 1'h1;
    poll(32'h7, 32'(ST_RECORD), 50);
    tapeEnd <= 1'h1;
    @(posedge sys_clk);
    tapeEnd <= 1'h0;
    poll(32'h7, 32'(ST_IDLE), 50);
    chk1(tapeOutLamp, 1'h1);
    $display("test record stop and tape out done");
    powerSwitch <= 1'h0;
    poll(32'h7, 32'(ST_OFF), 50);
    chk1(holdDiscard, 1'h1);
    chk1(collectEnable, 1'h0);
    consolePresent <= 1'h1;
    repeat (4) @(posedge sys_clk);
    powerSwitch <= 1'h1;
    poll(32'h7, 32'(ST_IDLE), 100);
    poll(32'h80, 32'h80, 1);
    chk1(writtenLamp, 1'h0);
    $display("test power cycle done");
    apb(1'h1, PLAYSTART_OFFSET, 32'h00F3_87C1);
    rdchk(PLAYSTART_OFFSET, 32'hFFFF_FFFF, 32'h0);
    apb(1'h1, PLAYSTART_OFFSET, 32'h00F3_87C0);
    rdchk(PLAYSTART_OFFSET, 32'hFFFF_FFFF, 32'h00F3_87C0);
    apb(1'h1, PLAYSTART_OFFSET, 32'h0000_0064);
    apb(1'h1, PLAYSTOP_OFFSET, 32'h0000_1770);
    apb(1'h1, CTRL_OFFSET, 32'h0000_0105);
    poll(32'h7, 32'(ST_SEEK), 10);
    chk1(tapeSeek, 1'h1);
    poll(32'h7, 32'(ST_PLAYBACK), 100);
    chk1(transmitMode, 1'h1);
    recordSwitch <= 1'h0;
    repeat (8) @(posedge sys_clk);
    poll(32'h7, 32'(ST_PLAYBACK), 1);
    poll(32'h7, 32'(ST_IDLE), 3000);
    chk32(blockCount, (6000 - 100) / PLAYBACK_BLOCK_WORDS);
    $display("test playback done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
